// ---- design/wdrt_pkg.sv ----
/*
  Shared constants and types for the watchdog refresh/timeout block.
  Assumes a 32-bit AXI4-Lite register bus and a slow watchdog oscillator
  that is sampled as an ordinary input in the system clock domain.
*/
package wdrt_pkg;

  // ----------------------------------------------------------------
  // Widths and counter values
  // ----------------------------------------------------------------
  localparam int WDRT_RELOAD_W = 24;
  localparam int WDRT_ADDR_W = 8;
  localparam logic [23:0] WDRT_COUNT_MAX = 24'hFFFFFF;
  localparam logic [23:0] WDRT_RELOAD_MIN = 24'h000004;
  localparam logic [23:0] WDRT_RELOAD_RST = 24'hFFFFFF;
  localparam int WDRT_OSC_TYP_HZ = 10000;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] WDRT_ADDR_CTRL = 8'h00;
  localparam logic [7:0] WDRT_ADDR_STAT = 8'h04;
  localparam logic [7:0] WDRT_ADDR_RELOAD = 8'h08;
  localparam logic [7:0] WDRT_ADDR_COUNT = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int WDRT_CTRL_EN_BIT = 0;
  localparam int WDRT_CTRL_REFRESH_BIT = 1;
  localparam int WDRT_CTRL_RESP_BIT = 8;
  localparam int WDRT_STAT_TO_BIT = 0;
  localparam int WDRT_STAT_STOP_BIT = 1;
  localparam int WDRT_STAT_POR_BIT = 2;
  localparam logic WDRT_EN_RST = 1'b0;
  localparam logic WDRT_POR_RST = 1'b1;
  localparam logic WDRT_RESP_IRQ = 1'b1;
  localparam logic WDRT_RESP_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] WDRT_RESP_OKAY = 2'h0;
  localparam logic [1:0] WDRT_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    WDRT_IDLE = 1'b0,
    WDRT_RUN = 1'b1
  } wdrt_state_e;

  typedef struct packed {
    logic por;
    logic stop;
    logic timeout_flag;
  } wdrt_flags_s;

endpackage

// ---- design/wdrt_tick_sync.sv ----
/*
  Brings the watchdog oscillator into the system clock domain and emits
  one-cycle ticks on its rising edges.
  Assumes the oscillator is far slower than aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module wdrt_tick_sync
  import wdrt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_in,
  output logic tick
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Two-flop synchroniser; only the second stage feeds the edge detector.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      tick <= 1'b0;
    end else begin
      meta_reg <= osc_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      tick <= sync_reg & ~last_reg;
    end
  end
endmodule // wdrt_tick_sync
`default_nettype wire

// ---- design/wdrt_counter.sv ----
/*
  The 24-bit watchdog down-counter with load, refresh and wrap.
  Assumes tick is a single-cycle pulse from the synchroniser.
*/
`timescale 1ns/100ps
`default_nettype none
module wdrt_counter
  import wdrt_pkg::*;
#(
  parameter int W = WDRT_RELOAD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic refresh,
  input wire logic tick,
  input wire logic [W-1:0] reload_in,
  output logic [W-1:0] count,
  output logic timeout
);
  wdrt_state_e state_reg;

  // Counter state; refresh has priority over a tick in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= WDRT_IDLE;
      count <= '0;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      unique case (state_reg)
        WDRT_IDLE: begin
          if (enable) begin
            count <= reload_in;
            state_reg <= WDRT_RUN;
          end
        end
        WDRT_RUN: begin
          if (!enable) begin
            state_reg <= WDRT_IDLE;
          end else if (refresh) begin
            count <= reload_in;
          end else if (tick) begin
            // Zero wraps to all ones; no automatic reload.
            count <= count - 1'b1;
            timeout <= (count == W'(1));
          end
        end
      endcase
    end
  end

  a_first_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_reg == WDRT_IDLE && enable |=> count == $past(reload_in))
    else $error("counter not loaded on first enable");
  a_refresh_load: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_reg == WDRT_RUN && enable && refresh
    |=> count == $past(reload_in))
    else $error("refresh did not reload counter");
  a_wrap_max: assert property (
    @(posedge aclk) disable iff (!aresetn)
    state_reg == WDRT_RUN && enable && !refresh && tick && count == '0
    |=> count == {W{1'b1}})
    else $error("counter did not wrap to all ones");
  a_timeout_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout |-> count == '0 && $past(tick))
    else $error("timeout without count reaching zero");
endmodule // wdrt_counter
`default_nettype wire

// ---- design/wdrt_top.sv ----
/*
  Watchdog refresh/timeout block with an AXI4-Lite register slave.
  Assumes the CPU pulses refresh_instr when it runs its refresh
  instruction, and that the option bit is stable at reset release.
*/
// Operation
// - First enable loads the counter from the reload register.
// - Counter then decrements toward zero unless refreshed.
// - Refresh instruction reloads the counter and counting resumes.
// - Debug mode refreshes continuously so no timeout occurs.
// - Counter reaching zero is a timeout; option bit picks interrupt or reset.
// - Interrupt response raises request and sets the timeout flag.
// - After interrupt timeout the counter wraps to all ones and continues.
// - No automatic reload after timeout; only refresh, or disabling and re-enabling, restores it.
// - In stop mode, an interrupt-response timeout starts recovery and sets timeout and stop flags.
// - Reload value is 24 bits wide.
// - Power-on reset sets the power-on flag to one.
`timescale 1ns/100ps
`default_nettype none
module wdrt_top
  import wdrt_pkg::*;
#(
  parameter int AW = WDRT_ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wdog_osc,
  input wire logic refresh_instr,
  input wire logic debug_mode,
  input wire logic stop_mode,
  input wire logic timeout_response_select,
  output logic irq_req,
  output logic sys_reset_req,
  output logic stop_recover
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // True for every address that maps a register.
  function automatic logic addr_ok(input logic [AW-1:0] a);
    addr_ok = (a == AW'(WDRT_ADDR_CTRL)) || (a == AW'(WDRT_ADDR_STAT)) ||
              (a == AW'(WDRT_ADDR_RELOAD)) || (a == AW'(WDRT_ADDR_COUNT));
  endfunction

  // Merges byte lanes of new data into old data under the strobes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic en_reg;
  logic [WDRT_RELOAD_W-1:0] reload_reg;
  wdrt_flags_s flags_reg;
  logic resp_sel_reg;
  logic strap_done_reg;
  logic sw_refresh_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic tick;
  logic timeout;
  logic refresh_any;
  logic [WDRT_RELOAD_W-1:0] count;
  logic [31:0] wr_merged;
  logic [31:0] reload_merged;
  wdrt_flags_s clr_mask;

  // ----------------------------------------------------------------
  // Oscillator tick and down-counter
  // ----------------------------------------------------------------
  wdrt_tick_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_in(wdog_osc),
    .tick(tick)
  );

  // Debug mode holds the refresh asserted so the count never expires.
  assign refresh_any = refresh_instr | sw_refresh_reg | debug_mode;

  wdrt_counter #(
    .W(WDRT_RELOAD_W)
  ) u_cnt (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(en_reg),
    .refresh(refresh_any),
    .tick(tick),
    .reload_in(reload_reg),
    .count(count),
    .timeout(timeout)
  );

  // ----------------------------------------------------------------
  // Option bit capture
  // ----------------------------------------------------------------

  // Caught once after reset release; later changes of the pin are ignored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_sel_reg <= WDRT_RESP_RESET;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      resp_sel_reg <= timeout_response_select;
      strap_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_merged = merge(32'h00000000, w_data_reg, w_strb_reg);

  // Address and data are taken independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= WDRT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr_reg) ? WDRT_RESP_OKAY
                                           : WDRT_RESP_SLVERR;
      end
      // Readies re-arm only after the response, so one write at a time.
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register: enable and software refresh
  // ----------------------------------------------------------------

  // The refresh bit is a one-cycle strobe and reads back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg <= WDRT_EN_RST;
      sw_refresh_reg <= 1'b0;
    end else begin
      sw_refresh_reg <= 1'b0;
      if (do_write && aw_addr_reg == AW'(WDRT_ADDR_CTRL) && w_strb_reg[0]) begin
        en_reg <= w_data_reg[WDRT_CTRL_EN_BIT];
        sw_refresh_reg <= w_data_reg[WDRT_CTRL_REFRESH_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Reload register
  // ----------------------------------------------------------------

  // Byte lanes of a reload write merge into the current value.
  assign reload_merged = merge({8'h00, reload_reg}, w_data_reg, w_strb_reg);

  // Writes take effect at the next load or refresh, not mid-count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_reg <= WDRT_RELOAD_RST;
    end else if (do_write && aw_addr_reg == AW'(WDRT_ADDR_RELOAD)) begin
      reload_reg <= reload_merged[WDRT_RELOAD_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags and timeout response
  // ----------------------------------------------------------------
  always_comb begin
    clr_mask = '0;
    if (do_write && aw_addr_reg == AW'(WDRT_ADDR_STAT)) begin
      clr_mask.timeout_flag = wr_merged[WDRT_STAT_TO_BIT];
      clr_mask.stop = wr_merged[WDRT_STAT_STOP_BIT];
      clr_mask.por = wr_merged[WDRT_STAT_POR_BIT];
    end
  end

  // Write-one-to-clear; a timeout in the same cycle wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg.timeout_flag <= 1'b0;
      flags_reg.stop <= 1'b0;
      flags_reg.por <= WDRT_POR_RST;
      irq_req <= 1'b0;
      sys_reset_req <= 1'b0;
      stop_recover <= 1'b0;
    end else begin
      irq_req <= 1'b0;
      sys_reset_req <= 1'b0;
      stop_recover <= 1'b0;
      flags_reg <= flags_reg & ~clr_mask;
      if (timeout) begin
        if (resp_sel_reg == WDRT_RESP_IRQ) begin
          irq_req <= 1'b1;
          flags_reg.timeout_flag <= 1'b1;
          if (stop_mode) begin
            stop_recover <= 1'b1;
            flags_reg.stop <= 1'b1;
          end
        end else begin
          sys_reset_req <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------

  // Read data is captured on the address handshake and held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= WDRT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= addr_ok(s_axi_araddr) ? WDRT_RESP_OKAY
                                          : WDRT_RESP_SLVERR;
      s_axi_rdata <= 32'h00000000;
      if (s_axi_araddr == AW'(WDRT_ADDR_CTRL)) begin
        s_axi_rdata[WDRT_CTRL_EN_BIT] <= en_reg;
        s_axi_rdata[WDRT_CTRL_RESP_BIT] <= resp_sel_reg;
      end else if (s_axi_araddr == AW'(WDRT_ADDR_STAT)) begin
        s_axi_rdata[WDRT_STAT_TO_BIT] <= flags_reg.timeout_flag;
        s_axi_rdata[WDRT_STAT_STOP_BIT] <= flags_reg.stop;
        s_axi_rdata[WDRT_STAT_POR_BIT] <= flags_reg.por;
      end else if (s_axi_araddr == AW'(WDRT_ADDR_RELOAD)) begin
        s_axi_rdata[WDRT_RELOAD_W-1:0] <= reload_reg;
      end else if (s_axi_araddr == AW'(WDRT_ADDR_COUNT)) begin
        s_axi_rdata[WDRT_RELOAD_W-1:0] <= count;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_por_after_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> flags_reg.por)
    else $error("power-on flag not set after reset");
  a_irq_on_timeout: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && resp_sel_reg == WDRT_RESP_IRQ
    |=> irq_req && flags_reg.timeout_flag && !sys_reset_req)
    else $error("interrupt timeout missing request or flag");
  a_reset_on_timeout: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && resp_sel_reg == WDRT_RESP_RESET
    |=> sys_reset_req && !irq_req)
    else $error("reset timeout did not request reset");
  a_stop_recovery: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && resp_sel_reg == WDRT_RESP_IRQ && stop_mode
    |=> stop_recover && flags_reg.stop && flags_reg.timeout_flag)
    else $error("stop-mode timeout missed recovery");
  a_debug_no_timeout: assert property (
    @(posedge aclk) disable iff (!aresetn)
    debug_mode && $past(debug_mode) |-> !timeout)
    else $error("timeout while in debug mode");
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write response not raised");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready)
    else $error("read data not returned next cycle");

endmodule // wdrt_top
`default_nettype wire

// ---- test/wdrt_cpu_model.sv ----
/*
  Model of the CPU and interrupt controller beside the watchdog block.
  Assumes it shares aclk with the block and is steered through its tasks.
*/
`timescale 1ns/100ps
`default_nettype none
module wdrt_cpu_model (
  input wire logic aclk,
  input wire logic irq_req,
  input wire logic sys_reset_req,
  input wire logic stop_recover,
  output logic wdog_osc,
  output logic refresh_instr
);
  int irq_cnt = 0;
  int rst_cnt = 0;
  int rec_cnt = 0;

  initial begin
    wdog_osc = 1'b0;
    refresh_instr = 1'b0;
  end

  // Each request pulse is counted once, as the controller latches it.
  always @(posedge aclk) begin
    if (irq_req === 1'b1) irq_cnt++;
    if (sys_reset_req === 1'b1) rst_cnt++;
    if (stop_recover === 1'b1) rec_cnt++;
  end

  // Slow oscillator bursts; it stands low between them so reads are calm.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge aclk) wdog_osc <= 1'b1;
      repeat (4) @(posedge aclk);
      wdog_osc <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    repeat (6) @(posedge aclk);
  endtask

  // The refresh instruction shows as one cycle high.
  task automatic refresh();
    @(posedge aclk) refresh_instr <= 1'b1;
    @(posedge aclk) refresh_instr <= 1'b0;
  endtask
endmodule // wdrt_cpu_model
`default_nettype wire

// ---- test/tb_top.sv ----
/*
  Self-checking bench for the watchdog block with an integer model.
  Assumes the package constants and the CPU model of this folder.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import wdrt_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, wdog_osc, refresh_instr;
  logic debug_mode, stop_mode, timeout_response_select;
  logic irq_req, sys_reset_req, stop_recover;
  logic [31:0] seed = 32'hC6F39CB6;
  logic [31:0] v, stat_m;
  int err_total = 0;
  int n_compared = 0;
  int cnt_m, rel_m, en_m, irq_m, rst_m, rec_m;

  wdrt_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wdog_osc,
    .refresh_instr, .debug_mode, .stop_mode, .timeout_response_select,
    .irq_req, .sys_reset_req, .stop_recover);
  wdrt_cpu_model cpu_u (.aclk, .irq_req, .sys_reset_req, .stop_recover,
    .wdog_osc, .refresh_instr);

  // Free-running 125 MHz system clock.
  always #4 aclk = ~aclk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Write: address and data offered together, each dropped when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Only the bench watchdog ends a wait whose answer never comes.
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rel_m = 24'hFFFFFF;
    cnt_m = 0;
    en_m = 0;
    stat_m = 32'h4;
  endtask

  // Oscillator ticks, mirrored one by one in the integer model.
  task automatic tick(input int n);
    cpu_u.pulses(n);
    repeat (n) begin
      if (en_m == 0) continue;
      if (debug_mode === 1'b1) cnt_m = rel_m;
      else begin
        if (cnt_m == 1 && timeout_response_select) begin
          irq_m++;
          stat_m |= 32'h1;
          if (stop_mode) rec_m++;
          if (stop_mode) stat_m |= 32'h2;
        end else if (cnt_m == 1) rst_m++;
        cnt_m = (cnt_m - 1) & 24'hFFFFFF;
      end
    end
  endtask

  task automatic cmp_all();
    rd(WDRT_ADDR_COUNT, cnt_m, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_STAT, stat_m, WDRT_RESP_OKAY);
    chk(cpu_u.irq_cnt, irq_m);
    chk(cpu_u.rst_cnt, rst_m);
    chk(cpu_u.rec_cnt, rec_m);
  endtask

  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // A hang ends the run through the same verdict.
  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, debug_mode, stop_mode} = '0;
    timeout_response_select = 1'b1;
    {irq_m, rst_m, rec_m} = '0;
    do_reset();
    rd(WDRT_ADDR_CTRL, 32'h100, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_STAT, 32'h4, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_RELOAD, 32'hFFFFFF, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_COUNT, 32'h0, WDRT_RESP_OKAY);
    rd(8'h10, 32'h0, WDRT_RESP_SLVERR);
    wr(8'h10, 32'h1, 4'hF, WDRT_RESP_SLVERR);
    $display("test reset values done");
    v = xs();
    wr(WDRT_ADDR_RELOAD, v, 4'hF, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_RELOAD, v & 32'hFFFFFF, WDRT_RESP_OKAY);
    wr(WDRT_ADDR_RELOAD, 32'hFFFFFFA5, 4'h1, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_RELOAD, {8'h0, v[23:8], 8'hA5}, WDRT_RESP_OKAY);
    wr(WDRT_ADDR_STAT, 32'h7, 4'hF, WDRT_RESP_OKAY);
    stat_m = 0;
    $display("test reload width done");
    rel_m = 4;
    wr(WDRT_ADDR_RELOAD, 32'h4, 4'hF, WDRT_RESP_OKAY);
    wr(WDRT_ADDR_CTRL, 32'h1, 4'hF, WDRT_RESP_OKAY);
    en_m = 1;
    cnt_m = rel_m;
    cmp_all();
    tick(3);
    cmp_all();
    tick(1);
    cmp_all();
    tick(2);
    cmp_all();
    cpu_u.refresh();
    cnt_m = rel_m;
    tick(1);
    cmp_all();
    wr(WDRT_ADDR_CTRL, 32'h3, 4'hF, WDRT_RESP_OKAY);
    cnt_m = rel_m;
    cmp_all();
    rd(WDRT_ADDR_CTRL, 32'h101, WDRT_RESP_OKAY);
    $display("test interrupt timeout done");
    debug_mode <= 1'b1;
    tick(10);
    debug_mode <= 1'b0;
    cmp_all();
    $display("test debug refresh done");
    wr(WDRT_ADDR_STAT, 32'h7, 4'hF, WDRT_RESP_OKAY);
    stat_m = 0;
    rel_m = 4 + int'(xs() % 13);
    wr(WDRT_ADDR_RELOAD, rel_m, 4'hF, WDRT_RESP_OKAY);
    cpu_u.refresh();
    cnt_m = rel_m;
    stop_mode <= 1'b1;
    tick(rel_m + 1);
    stop_mode <= 1'b0;
    cmp_all();
    wr(WDRT_ADDR_CTRL, 32'h0, 4'hF, WDRT_RESP_OKAY);
    en_m = 0;
    tick(3);
    cmp_all();
    $display("test stop recovery done");
    timeout_response_select <= 1'b0;
    do_reset();
    rd(WDRT_ADDR_STAT, 32'h4, WDRT_RESP_OKAY);
    rd(WDRT_ADDR_CTRL, 32'h0, WDRT_RESP_OKAY);
    rel_m = 5;
    wr(WDRT_ADDR_RELOAD, 32'h5, 4'hF, WDRT_RESP_OKAY);
    wr(WDRT_ADDR_CTRL, 32'h1, 4'hF, WDRT_RESP_OKAY);
    en_m = 1;
    cnt_m = rel_m;
    tick(6);
    cmp_all();
    $display("test reset response done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
